// ---- verilog/serial_slave_consts.vh ----
// constants for the binary serial slave message handler
`ifndef SERIAL_SLAVE_CONSTS_VH
`define SERIAL_SLAVE_CONSTS_VH
// control characters
`define CH_EOT        8'h04
`define CH_STX        8'h02
`define CH_ENQ        8'h05
`define CH_ETX        8'h03
`define CH_ETB        8'h17
`define CH_ACK        8'h06
`define CH_NAK        8'h15
`define DATA_BIT      7
`define BLOCK_MAX     4'h8
`define PSEUDO_PNO    7'h07
`define BLOCK_MASK    7'h07
// parameter indices
`define P_IDENT       7'h00
`define P_ERROR       7'h01
`define P_OPTVER      7'h03
`define P_CHBAND      7'h04
`define P_LINKCFG     7'h05
`define P_BUFLEN      7'h06
`define P_PSEUDO      7'h07
`define P_CAPINFO     7'h08
`define P_FMTCAP      7'h09
`define P_VERSION     7'h0a
`define P_LAST        7'h0a
// reset and fixed values
`define V_BUFLEN      16'h4646
`define V_CAPINFO     16'h4ccc
`define V_FMTCAP      16'h08c1
`define E_NONE        16'h00c0
`define E_UNKNOWN     16'h01c7
`define E_BCC         16'h02c2
`define E_PARITY      16'h03c1
`define E_FRAMING     16'h03c2
`define E_READONLY    16'h05c8
`define E_FORMAT      16'h07c7
`define E_RANGE       16'h08c8
// value bounds and format code
`define FMT_MAX       5'h04
`define BAUD_MAX      3'h5
`endif

// ---- verilog/serial_slave.v ----
// binary serial protocol slave: message parsing, parameters and replies
`include "serial_slave_consts.vh"
`timescale 1ns/100ps
`default_nettype none

module serial_slave #(
    parameter [15:0] IDENT_DEFAULT = 16'h1234,
    parameter [15:0] VERSION_VALUE = 16'h0100,
    parameter [15:0] OPTION_VALUE  = 16'h0000
) (
    input  wire       core_clk_i,
    input  wire       rst_i,
    input  wire [6:0] unit_address_i,
    input  wire       rx_valid_i,
    input  wire [7:0] rx_char_i,
    input  wire       rx_parity_err_i,
    input  wire       rx_frame_err_i,
    input  wire       tx_ready_i,
    output reg        tx_valid_o,
    output reg  [7:0] tx_char_o,
    output reg  [2:0] baud_sel_o,
    output reg  [15:0] changeband_o
);

// ********************************
// parser states
// ********************************
localparam [4:0] S_IDLE = 5'b00001;
localparam [4:0] S_BODY = 5'b00010;
localparam [4:0] S_BCC  = 5'b00100;
localparam [4:0] S_SEND = 5'b01000;
localparam [4:0] S_SKIP = 5'b10000;

reg [4:0]  state;
reg [7:0]  buf_c [0:9];
reg [3:0]  cnt;
reg        err_seen;
reg [15:0] link_error_report;
reg [15:0] instrument_identifier;
reg [6:0]  cur_pno;
reg [6:0]  remain;
reg        multi_mode;
reg        poll_valid;
reg [6:0]  last_start;
reg [6:0]  last_count;
reg        last_multi;
reg [6:0]  blk_left;
reg [3:0]  blk_items;
reg [2:0]  item_ph;
reg [7:0]  bcc;
reg        single_char;
reg [7:0]  single_val;
reg [6:0]  rep_start;
reg [6:0]  rep_count;
reg        rep_multi;
reg [4:0]  fmt_tbl;

wire is_data = rx_char_i[`DATA_BIT];

// ********************************
// helpers
// ********************************
function known;
    input [6:0] p;
    begin
        known = (p <= `P_LAST) && (p != 7'h02);
    end
endfunction

function [15:0] read_param;
    input [6:0]  p;
    input [15:0] ident;
    input [15:0] errr;
    input [15:0] band;
    input [2:0]  baud;
    begin
        case (p)
            `P_IDENT:   read_param = ident;
            `P_ERROR:   read_param = errr;
            `P_OPTVER:  read_param = OPTION_VALUE;
            `P_CHBAND:  read_param = band;
            `P_LINKCFG: read_param = {13'h0000, baud};
            `P_BUFLEN:  read_param = `V_BUFLEN;
            `P_CAPINFO: read_param = `V_CAPINFO;
            `P_FMTCAP:  read_param = `V_FMTCAP;
            `P_VERSION: read_param = VERSION_VALUE;
            default:    read_param = 16'h0000;
        endcase
    end
endfunction

// next index in circular list of supported parameters
function [6:0] next_param;
    input [6:0] p;
    begin
        if (p >= `P_LAST)
            next_param = `P_IDENT;
        else if (p == 7'h01)
            next_param = `P_OPTVER;
        else
            next_param = p + 7'h01;
    end
endfunction

wire [15:0] cur_val = read_param(cur_pno, instrument_identifier, link_error_report,
                                 changeband_o, baud_sel_o);

// three value characters, format 0 for all held values
wire [7:0] d1 = {1'b1, 5'h00, cur_val[15:14]};
wire [7:0] d2 = {1'b1, cur_val[13:7]};
wire [7:0] d3 = {1'b1, cur_val[6:0]};
wire [7:0] pch = {1'b1, cur_pno};
wire last_in_reply = (remain == 7'h01);
wire last_in_blk = last_in_reply || (blk_items == `BLOCK_MAX - 4'h1);

reg [7:0] item_char;
always @* begin
    case (item_ph)
        3'h0:    item_char = pch;
        3'h1:    item_char = d1;
        3'h2:    item_char = d2;
        3'h3:    item_char = d3;
        3'h4:    item_char = last_in_reply ? `CH_ETX : `CH_ETB;
        default: item_char = bcc;
    endcase
end

// ********************************
// selection decode
// ********************************
wire [6:0]  sel_pno = buf_c[3][6:0];
wire [15:0] sel_val = {buf_c[4][1:0], buf_c[5][6:0], buf_c[6][6:0]};
wire [4:0]  sel_fmt = buf_c[4][6:2];
wire        sel_ro  = (sel_pno == `P_OPTVER) || (sel_pno == `P_LINKCFG) ||
                      (sel_pno == `P_BUFLEN) || (sel_pno == `P_CAPINFO) ||
                      (sel_pno == `P_FMTCAP) || (sel_pno == `P_VERSION) ||
                      (sel_pno == `P_PSEUDO);
wire        sel_range = (sel_fmt > `FMT_MAX) ||
                        ((sel_pno == `P_LINKCFG) && (sel_val[2:0] > `BAUD_MAX));
wire [7:0]  sel_bcc = buf_c[3] ^ buf_c[4] ^ buf_c[5] ^ buf_c[6] ^ `CH_ETX;

// ********************************
// main process
// ********************************
always @(posedge core_clk_i) begin
    if (rst_i) begin
        state                 <= S_IDLE;
        cnt                   <= 4'h0;
        err_seen              <= 1'b0;
        link_error_report     <= `E_NONE;
        instrument_identifier <= IDENT_DEFAULT;
        baud_sel_o            <= `BAUD_MAX;
        changeband_o          <= 16'h0000;
        cur_pno               <= 7'h00;
        remain                <= 7'h00;
        multi_mode            <= 1'b0;
        poll_valid            <= 1'b0;
        last_start            <= 7'h00;
        last_count            <= 7'h00;
        last_multi            <= 1'b0;
        blk_items             <= 4'h0;
        blk_left              <= 7'h00;
        item_ph               <= 3'h0;
        bcc                   <= 8'h00;
        single_char           <= 1'b0;
        single_val            <= 8'h00;
        tx_valid_o            <= 1'b0;
        tx_char_o             <= 8'h00;
        rep_start             <= 7'h00;
        rep_count             <= 7'h00;
        rep_multi             <= 1'b0;
        fmt_tbl               <= 5'h00;
    end else begin
        if (rx_valid_i && (rx_parity_err_i || rx_frame_err_i))
            link_error_report <= rx_parity_err_i ? `E_PARITY : `E_FRAMING;
        case (state)
            S_IDLE, S_SKIP, S_BODY: begin
                if (rx_valid_i && (rx_char_i == `CH_EOT)) begin
                    state    <= S_BODY;
                    cnt      <= 4'h0;
                    err_seen <= 1'b0;
                end else if (rx_valid_i && (state == S_IDLE) && !is_data &&
                             ((rx_char_i == `CH_ACK) || (rx_char_i == `CH_NAK))) begin
                    // continuations only from a polled state, never after a selection
                    if ((rx_char_i == `CH_ACK) && poll_valid && multi_mode) begin
                        state     <= S_SEND;
                        item_ph   <= 3'h0;
                        bcc       <= 8'h00;
                        blk_items <= 4'h0;
                        tx_valid_o <= 1'b1;
                        tx_char_o  <= `CH_STX;
                        single_char <= 1'b0;
                        last_start <= cur_pno;
                        last_count <= remain;
                    end else if ((rx_char_i == `CH_NAK) && poll_valid) begin
                        cur_pno    <= last_start;
                        remain     <= last_count;
                        state      <= S_SEND;
                        item_ph    <= 3'h0;
                        bcc        <= 8'h00;
                        blk_items  <= 4'h0;
                        tx_valid_o <= 1'b1;
                        tx_char_o  <= `CH_STX;
                        single_char <= 1'b0;
                    end else begin
                        state <= S_SEND;
                        single_char <= 1'b1;
                        tx_valid_o <= 1'b1;
                        tx_char_o  <= `CH_NAK;
                    end
                end else if (rx_valid_i && (state == S_BODY)) begin
                    if (rx_parity_err_i || rx_frame_err_i)
                        err_seen <= 1'b1;
                    if (cnt < 4'ha)
                        buf_c[cnt] <= rx_char_i;
                    cnt <= cnt + 4'h1;
                    if (rx_char_i == `CH_ENQ) begin
                        // poll types; buf_c[0] is unit address
                        if (buf_c[0][6:0] != unit_address_i || err_seen) begin
                            state <= S_IDLE; // silent on foreign address or bad char
                        // data flag is on every char, so the sum covers the low bits only
                        end else if ((cnt == 4'h2 && buf_c[1] == buf_c[0]) ||
                                     (cnt == 4'h3 && buf_c[2][6:0] ==
                                      (buf_c[0][6:0] ^ buf_c[1][6:0])) ||
                                     (cnt == 4'h4 && buf_c[3][6:0] ==
                                      (buf_c[0][6:0] ^ buf_c[1][6:0] ^ buf_c[2][6:0]))) begin
                            state     <= S_SEND;
                            tx_valid_o <= 1'b1;
                            tx_char_o  <= `CH_STX;
                            single_char <= 1'b0;
                            item_ph   <= 3'h0;
                            bcc       <= 8'h00;
                            blk_items <= 4'h0;
                            poll_valid <= 1'b1;
                            if (cnt == 4'h2) begin
                                // enquiry poll reports block 0
                                cur_pno    <= `P_IDENT;
                                remain     <= {3'h0, `BLOCK_MAX};
                                multi_mode <= 1'b1;
                                last_start <= `P_IDENT;
                                last_count <= {3'h0, `BLOCK_MAX};
                            end else if (cnt == 4'h3) begin
                                cur_pno    <= known(buf_c[1][6:0]) ? buf_c[1][6:0]
                                                                   : `P_IDENT;
                                remain     <= 7'h01;
                                multi_mode <= 1'b0;
                                last_start <= buf_c[1][6:0];
                                last_count <= 7'h01;
                                if (!known(buf_c[1][6:0]))
                                    link_error_report <= `E_UNKNOWN;
                            end else begin
                                // pseudo-enquiry: any start, count from buf_c[2], zero read as one
                                cur_pno    <= buf_c[1][6:0];
                                remain     <= (buf_c[2][6:0] == 7'h00) ? 7'h01
                                                                      : buf_c[2][6:0];
                                multi_mode <= 1'b1;
                                last_start <= buf_c[1][6:0];
                                last_count <= buf_c[2][6:0];
                                rep_multi  <= ((buf_c[1][6:0] & `BLOCK_MASK) == 7'h00) &&
                                              (buf_c[2][6:0] == {3'h0, `BLOCK_MAX});
                            end
                        end else begin
                            state <= S_SEND;
                            single_char <= 1'b1;
                            tx_valid_o <= 1'b1;
                            tx_char_o  <= `CH_NAK;
                            link_error_report <= `E_FORMAT;
                        end
                    end else if (rx_char_i == `CH_ETX && cnt == 4'h7) begin
                        state <= S_BCC;
                    end else if (cnt > 4'h8) begin
                        state <= S_SKIP;
                    end
                end
            end
            S_BCC: begin
                if (rx_valid_i) begin
                    state <= S_SEND;
                    poll_valid <= 1'b0;
                    multi_mode <= 1'b0;
                    if (buf_c[0][6:0] != unit_address_i || err_seen ||
                        rx_parity_err_i || rx_frame_err_i) begin
                        state <= S_IDLE;
                    end else begin
                        single_char <= 1'b1;
                        tx_valid_o  <= 1'b1;
                        if (buf_c[1] != buf_c[0] || buf_c[2] != `CH_STX) begin
                            tx_char_o <= `CH_NAK;
                            link_error_report <= `E_FORMAT;
                        end else if (rx_char_i != sel_bcc) begin
                            tx_char_o <= `CH_NAK;
                            link_error_report <= `E_BCC;
                        end else if (!known(buf_c[3][6:0])) begin
                            tx_char_o <= `CH_NAK;
                            link_error_report <= `E_UNKNOWN;
                        end else if (sel_ro) begin
                            tx_char_o <= `CH_NAK;
                            link_error_report <= `E_READONLY;
                        end else if (sel_range) begin
                            tx_char_o <= `CH_NAK;
                            link_error_report <= `E_RANGE;
                        end else begin
                            tx_char_o <= `CH_ACK;
                            if (buf_c[3][6:0] == `P_ERROR)
                                link_error_report <= `E_NONE;
                            else if (buf_c[3][6:0] == `P_IDENT)
                                instrument_identifier <= sel_val;
                            else if (buf_c[3][6:0] == `P_CHBAND)
                                changeband_o <= sel_val;
                        end
                    end
                end
            end
            S_SEND: begin
                // only answers; never started without a message
                if (tx_ready_i) begin
                    if (single_char) begin
                        tx_valid_o <= 1'b0;
                        state <= S_IDLE;
                    end else begin
                        tx_char_o <= item_char;
                        if (item_ph < 3'h5)
                            bcc <= bcc ^ item_char;
                        if (item_ph == 3'h6) begin
                            tx_valid_o <= 1'b0;
                            state <= S_IDLE;
                        end else if (item_ph == 3'h4 || item_ph == 3'h3) begin
                            item_ph <= item_ph + 3'h1;
                        end else begin
                            item_ph <= item_ph + 3'h1;
                        end
                        if (item_ph == 3'h3 && !last_in_blk) begin
                            // more items in this block
                            item_ph   <= 3'h0;
                            blk_items <= blk_items + 4'h1;
                            remain    <= remain - 7'h01;
                            cur_pno   <= next_param(cur_pno);
                        end else if (item_ph == 3'h6) begin
                            remain  <= remain - 7'h01;
                            cur_pno <= next_param(cur_pno);
                            if (remain == 7'h01)
                                multi_mode <= 1'b0;
                        end
                    end
                end
            end
            default: state <= S_IDLE;
        endcase
    end
end

endmodule

`default_nettype wire

// ---- bench/serial_slave_properties.sv ----
// port-level checks on the serial slave message handler
`timescale 1ns/100ps
`default_nettype none
`include "serial_slave_consts.vh"
module serial_slave_properties (
    input wire logic        core_clk_i,
    input wire logic        rst_i,
    input wire logic [6:0]  unit_address_i,
    input wire logic        rx_valid_i,
    input wire logic [7:0]  rx_char_i,
    input wire logic        rx_parity_err_i,
    input wire logic        rx_frame_err_i,
    input wire logic        tx_ready_i,
    input wire logic        tx_valid_o,
    input wire logic [7:0]  tx_char_o,
    input wire logic [2:0]  baud_sel_o,
    input wire logic [15:0] changeband_o
);
    // ******************************
    // assertions
    // ******************************
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    a_reset_idle_out: assert property (disable iff (1'b0) rst_i |=> !tx_valid_o &&
        baud_sel_o == 3'h5 && changeband_o == 16'h0000) else $error("outputs wrong after reset");
    a_baud_in_range: assert property (baud_sel_o <= `BAUD_MAX)
        else $error("baud select beyond six rates");
    a_char_holds_stall: assert property (tx_valid_o && !tx_ready_i |=>
        tx_valid_o && $stable(tx_char_o)) else $error("reply char dropped while stalled");
    a_only_answers: assert property ($rose(tx_valid_o) |-> $past(rx_valid_i))
        else $error("reply started without a received char");
    a_settings_on_msg: assert property ($changed(changeband_o) || $changed(baud_sel_o) |->
        $past(rx_valid_i) || $past(rst_i)) else $error("setting changed with no message");
    a_rx_error_quiet: assert property (rx_valid_i && (rx_parity_err_i || rx_frame_err_i)
        |=> !$rose(tx_valid_o)) else $error("reply to a char with a line error");
    a_eot_no_reply: assert property (rx_valid_i && rx_char_i == `CH_EOT |=>
        !$rose(tx_valid_o)) else $error("reply to end of transmission");
    a_reply_first_char: assert property ($rose(tx_valid_o) |->
        tx_char_o inside {`CH_STX, `CH_ACK, `CH_NAK, `CH_EOT}) else $error("bad first reply char");
    a_stx_then_data: assert property (tx_valid_o && tx_ready_i && tx_char_o == `CH_STX
        |=> !tx_valid_o || tx_char_o[7]) else $error("char after start of text not data");
    c_ack_sent: cover property ($rose(tx_valid_o) && tx_char_o == `CH_ACK);
    c_nak_sent: cover property ($rose(tx_valid_o) && tx_char_o == `CH_NAK);
    c_block_sent: cover property ($rose(tx_valid_o) && tx_char_o == `CH_STX);
    c_stalled: cover property (tx_valid_o && !tx_ready_i);
endmodule
bind serial_slave serial_slave_properties i_props (.core_clk_i, .rst_i, .unit_address_i,
    .rx_valid_i, .rx_char_i, .rx_parity_err_i, .rx_frame_err_i, .tx_ready_i, .tx_valid_o,
    .tx_char_o, .baud_sel_o, .changeband_o);
`default_nettype wire

// ---- bench/supervisor_model.sv ----
// supervisor model: link master that frames messages and collects replies
`timescale 1ns/100ps
`default_nettype none
`include "serial_slave_consts.vh"
module supervisor_model (
    input  wire logic       core_clk_i,
    input  wire logic [6:0] addr_i,
    input  wire logic       tx_valid_i,
    input  wire logic [7:0] tx_char_i,
    output logic            rx_valid_o,
    output logic [7:0]      rx_char_o,
    output logic            rx_parity_err_o,
    output logic            rx_frame_err_o,
    output logic            tx_ready_o
);
    // ******************************
    // character driver and collector
    // ******************************
    logic [7:0] got[$];
    bit         slow = 1'b0;
    initial begin
        rx_valid_o = 1'b0;
        rx_char_o = 8'h00;
        rx_parity_err_o = 1'b0;
        rx_frame_err_o = 1'b0;
    end
    always @(posedge core_clk_i) begin
        if (tx_valid_i && tx_ready_o) begin
            got.push_back(tx_char_i);
        end
    end
    // slow master stalls at random to stretch replies
    always @(negedge core_clk_i) begin
        tx_ready_o <= slow ? 1'($urandom_range(1, 0)) : 1'b1;
    end
    task automatic send(input logic [7:0] c, input logic perr);
        @(negedge core_clk_i);
        rx_valid_o = 1'b1;
        rx_char_o = c;
        rx_parity_err_o = perr;
        @(negedge core_clk_i);
        rx_valid_o = 1'b0;
        rx_char_o = ~c; // released line must not show the old char
        rx_parity_err_o = 1'b0;
    endtask
    // fault[0] marks a parity error, fault[1] spoils the check char
    task automatic poll(input logic [6:0] parameter_index, input logic [6:0] cnt, input bit multi,
                        input logic [1:0] fault);
        logic [6:0] ccc;
        ccc = addr_i ^ parameter_index ^ (multi ? cnt : 7'h00) ^ {6'h00, fault[1]};
        send(`CH_EOT, 1'b0);
        send({1'b1, addr_i}, 1'b0);
        send({1'b1, parameter_index}, fault[0]);
        if (multi) send({1'b1, cnt}, 1'b0);
        send({1'b1, ccc}, 1'b0);
        send(`CH_ENQ, 1'b0);
    endtask
    task automatic select(input logic [6:0] parameter_index, input logic [15:0] v, input bit bad);
        logic [7:0] f[5];
        logic [7:0] bcc;
        f = '{{1'b1, parameter_index}, {6'h20, v[15:14]}, {1'b1, v[13:7]}, {1'b1, v[6:0]}, `CH_ETX};
        bcc = {7'h00, bad};
        send(`CH_EOT, 1'b0);
        send({1'b1, addr_i}, 1'b0);
        send({1'b1, addr_i}, 1'b0);
        send(`CH_STX, 1'b0);
        foreach (f[i]) begin
            send(f[i], 1'b0);
            bcc ^= f[i];
        end
        send(bcc, 1'b0);
    endtask
endmodule
`default_nettype wire

// ---- bench/testbench.sv ----
// self-checking bench: serial slave against a behavioural reply model
`timescale 1ns/100ps
`default_nettype none
`include "serial_slave_consts.vh"
module testbench;
    // ******************************
    // setup, model and checks
    // ******************************
    localparam logic [15:0] IDENT_DEF = 16'h1234; // arbitrary identity value
    localparam logic [15:0] VER_VAL   = 16'h0201;
    localparam logic [15:0] OPT_VAL   = 16'h0000;
    logic        core_clk;
    logic        rst;
    logic [6:0]  unit_addr;
    logic [6:0]  host_addr;
    logic        rx_valid;
    logic [7:0]  rx_char;
    logic        rx_parity_err;
    logic        rx_frame_err;
    logic        tx_ready;
    logic        tx_valid;
    logic [7:0]  tx_char;
    logic [2:0]  baud_sel;
    logic [15:0] changeband;
    logic [15:0] ident;
    logic [15:0] errc;
    logic [15:0] v;
    logic [7:0]  bcc_acc;
    logic [7:0]  exp_q[$];
    int          bad_count = 0;
    int          comparisons = 0;
    int          cycles = 0;
    int          plist[8] = '{0, 1, 3, 4, 6, 8, 9, 10};
    serial_slave #(.IDENT_DEFAULT(IDENT_DEF), .VERSION_VALUE(VER_VAL), .OPTION_VALUE(OPT_VAL))
        i_serial_slave (.core_clk_i(core_clk), .rst_i(rst), .unit_address_i(unit_addr),
        .rx_valid_i(rx_valid), .rx_char_i(rx_char), .rx_parity_err_i(rx_parity_err),
        .rx_frame_err_i(rx_frame_err), .tx_ready_i(tx_ready), .tx_valid_o(tx_valid),
        .tx_char_o(tx_char), .baud_sel_o(baud_sel), .changeband_o(changeband));
    supervisor_model i_supervisor_model (.core_clk_i(core_clk), .addr_i(host_addr),
        .tx_valid_i(tx_valid), .tx_char_i(tx_char), .rx_valid_o(rx_valid), .rx_char_o(rx_char),
        .rx_parity_err_o(rx_parity_err), .rx_frame_err_o(rx_frame_err), .tx_ready_o(tx_ready));
    task automatic print_verdict();
        if (bad_count == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] want);
        comparisons++;
        if (seen !== want) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", what, want, seen);
        end
    endtask
    function automatic logic [15:0] value(input int p);
        case (p % 11)
            0: return ident;
            1: return errc;
            3: return OPT_VAL;
            4: return 16'h0000;
            6: return `V_BUFLEN;
            8: return `V_CAPINFO;
            9: return `V_FMTCAP;
            default: return VER_VAL;
        endcase
    endfunction
    task automatic put(input logic [7:0] c);
        exp_q.push_back(c);
        bcc_acc ^= c;
    endtask
    // one reply block: items p..p+n-1, indices taken modulo 11, closed by last
    task automatic reply(input int p, input int n, input logic [7:0] last);
        logic [15:0] d;
        exp_q.push_back(`CH_STX);
        bcc_acc = 8'h00;
        for (int i = 0; i < n; i++) begin
            d = value(p + i);
            put({1'b1, 7'((p + i) % 11)});
            put({6'h20, d[15:14]});
            put({1'b1, d[13:7]});
            put({1'b1, d[6:0]});
        end
        put(last);
        exp_q.push_back(bcc_acc);
    endtask
    // wait for the expected count, then a quiet spell to catch extra chars
    task automatic settle();
        int k;
        k = 0;
        while (i_supervisor_model.got.size() < exp_q.size() && k < 3000) begin
            @(posedge core_clk);
            k++;
        end
        repeat (30) @(posedge core_clk);
        check("reply length", 16'(i_supervisor_model.got.size()), 16'(exp_q.size()));
        foreach (exp_q[j]) begin
            if (j < i_supervisor_model.got.size()) begin
                check("reply char", {8'h00, i_supervisor_model.got[j]}, {8'h00, exp_q[j]});
            end
        end
        i_supervisor_model.got.delete();
        exp_q.delete();
    endtask
    task automatic poll_and_check(input int p);
        i_supervisor_model.poll(7'(p), 7'h00, 1'b0, 2'b00);
        reply(p, 1, `CH_ETX);
        settle();
    endtask
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            print_verdict();
        end
    end
    initial begin
        void'($urandom(32'h9bcf));
        rst = 1'b1;
        unit_addr = 7'($urandom_range(126, 1));
        host_addr = unit_addr;
        ident = IDENT_DEF;
        errc = `E_NONE;
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
        rst = 1'b0;
        check("baud select", {13'h0000, baud_sel}, 16'h0005);
        foreach (plist[i]) begin
            poll_and_check(plist[i]);
        end
        i_supervisor_model.send(`CH_NAK, 1'b0);
        reply(10, 1, `CH_ETX);
        settle();
        i_supervisor_model.poll(7'h08, 7'h04, 1'b1, 2'b00);
        reply(8, 4, `CH_ETX);
        settle();
        i_supervisor_model.slow = 1'b1;
        v = 16'($urandom);
        i_supervisor_model.select(`P_IDENT, v, 1'b0);
        ident = v;
        exp_q.push_back(`CH_ACK);
        settle();
        poll_and_check(0);
        // read-only write, spoiled block check, then clearing write
        for (int k = 0; k < 3; k++) begin
            v = 16'($urandom);
            i_supervisor_model.select(k == 0 ? `P_BUFLEN : k == 1 ? `P_IDENT : `P_ERROR, v, k == 1);
            exp_q.push_back(k == 2 ? `CH_ACK : `CH_NAK);
            errc = k == 0 ? `E_READONLY : k == 1 ? `E_BCC : `E_NONE;
            settle();
            poll_and_check(1);
        end
        i_supervisor_model.poll(7'h00, 7'h00, 1'b0, 2'b01);
        errc = `E_PARITY;
        settle();
        poll_and_check(1);
        i_supervisor_model.poll(7'h00, 7'h00, 1'b0, 2'b10);
        exp_q.push_back(`CH_NAK);
        settle();
        host_addr = unit_addr ^ 7'h01;
        i_supervisor_model.poll(7'h00, 7'h00, 1'b0, 2'b00);
        settle();
        print_verdict();
    end
endmodule
`default_nettype wire
